// ===== clock_tick.sv
module clock_tick #(
  parameter int DIV_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic level,
  input wire logic restart,
  input wire logic [DIV_W-1:0] divide,
  output logic tick
);

  logic prev_reg;
  logic [DIV_W-1:0] phase_reg;
  logic rise;
  logic wrap;

  assign rise = level & ~prev_reg;
  // A divide value of zero behaves as one so the counter never stalls.
  assign wrap = (phase_reg + 1'b1 >= divide) | (phase_reg == {DIV_W{1'b1}});
  assign tick = rise & wrap;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= '0;
    end else if (restart) begin
      phase_reg <= '0;
    end else if (rise) begin
      phase_reg <= wrap ? '0 : phase_reg + 1'b1;
    end
  end

endmodule : clock_tick

// ===== freq_analyzer.sv
`include "freq_analyzer_map.svh"

// Notes on behaviour
// - Four modes: frequency with fast timebase, with slow timebase, period, trigger-bounded.
// - Period mode counts timebase edges over programmed test clock cycles.
// - Trigger mode: start edge opens the window, end edge closes it.
// - Without trigger mode, a write to the test counter starts measuring.
// - With trigger mode, a timebase counter write arms; start edge then starts.
// - Start polarity picks rising or falling start trigger edge.
// - End polarity picks rising or falling end trigger edge.
// - Start trigger is chosen from two inputs.
// - End trigger is chosen from two inputs.
// - One of sixteen test clocks feeds the test counter.
// - One of three timebase clocks feeds the timebase counter.
// - Selected test clock is divided by the predivide value before counting.
// - Pin connect bit routes the test clock to the output pin.
// - Separate target counts for both counters bound the measurement.
// - Timebase timeout during a measurement sets a status flag.
// - Status holds request flag plus above-max and below-min flags.
// - Three enables gate measurement, above-max and below-min request outputs.
// - Any timebase counter write clears stopped, started and timeout flags.
// - Low and high limits for both counters produce the limit flags.
// - Timebase count is captured at start and at completion.
module freq_analyzer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] test_clocks,
  input wire logic [2:0] timebase_clocks,
  input wire logic [1:0] start_trigger_in,
  input wire logic [1:0] end_trigger_in,
  input wire logic [`FA_ADDR_W-1:0] reg_addr,
  input wire logic [`FA_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`FA_DATA_W-1:0] reg_rdata,
  output logic test_clock_pin,
  output logic irq_measure,
  output logic irq_above_max,
  output logic irq_below_min
);

  freq_analyzer_pkg::ctrl_s ctrl_reg;
  freq_analyzer_pkg::phase_e phase_reg;
  freq_analyzer_pkg::phase_e phase_next;
  logic [`FA_IEN_W-1:0] irq_en_reg;
  logic [`FA_ST_W-1:0] status_reg;
  logic [`FA_ST_W-1:0] status_set;
  logic [`FA_ST_W-1:0] status_clr;
  logic [31:0] test_cnt_reg;
  logic [31:0] timebase_counter_reg;
  logic [31:0] test_target_reg;
  logic [31:0] tb_target_reg;
  logic [31:0] tb_start_cap_reg;
  logic [31:0] tb_end_cap_reg;
  logic [31:0] test_low_reg;
  logic [31:0] test_high_reg;
  logic [31:0] tb_low_reg;
  logic [31:0] tb_high_reg;
  logic start_prev_reg;
  logic end_prev_reg;

  logic wr_test_cnt;
  logic wr_tb_cnt;
  logic wr_abort;
  logic test_level;
  logic tb_level;
  logic start_level;
  logic end_level;
  logic test_tick;
  logic tb_tick;
  logic start_hit;
  logic end_hit;
  logic launch;
  logic arm;
  logic begin_run;
  logic finish;
  logic timeout;
  logic restart;
  logic [31:0] tb_cnt_next;
  logic [31:0] test_cnt_next;
  logic [31:0] tb_span;
  logic above;
  logic below;

  function automatic logic edge_seen(input logic cur, input logic prev, input logic falling);
    edge_seen = falling ? (prev & ~cur) : (cur & ~prev);
  endfunction : edge_seen

  function automatic logic write_at(input logic [`FA_ADDR_W-1:0] ofs);
    write_at = reg_write & (reg_addr == ofs);
  endfunction : write_at

  assign wr_test_cnt = write_at(`FA_TEST_CNT_OFS);
  assign wr_tb_cnt = write_at(`FA_TB_CNT_OFS);
  assign wr_abort = write_at(`FA_ABORT_OFS);

  assign test_level = test_clocks[ctrl_reg.test_clock_select];
  // Select code three has no timebase behind it and reads as a stopped clock.
  assign tb_level = (ctrl_reg.timebase_select == 2'h3) ? 1'b0
                  : timebase_clocks[ctrl_reg.timebase_select];
  assign start_level = start_trigger_in[ctrl_reg.start_trigger_select];
  assign end_level = end_trigger_in[ctrl_reg.end_trigger_select];

  assign start_hit = edge_seen(start_level, start_prev_reg, ctrl_reg.start_edge_polarity);
  assign end_hit = edge_seen(end_level, end_prev_reg, ctrl_reg.end_edge_polarity);

  assign launch = (phase_reg == freq_analyzer_pkg::IDLE) & wr_test_cnt
                & ~ctrl_reg.trigger_mode_enable;
  assign arm = (phase_reg == freq_analyzer_pkg::IDLE) & wr_tb_cnt
             & ctrl_reg.trigger_mode_enable;
  assign begin_run = launch | ((phase_reg == freq_analyzer_pkg::ARMED) & start_hit);
  assign restart = launch | arm;

  clock_tick #(
    .DIV_W(8)
  ) u_test_tick (
    .core_clk(core_clk),
    .reset(reset),
    .level(test_level),
    .restart(restart),
    .divide(ctrl_reg.prediv),
    .tick(test_tick)
  );

  clock_tick #(
    .DIV_W(8)
  ) u_tb_tick (
    .core_clk(core_clk),
    .reset(reset),
    .level(tb_level),
    .restart(restart),
    .divide(8'h01),
    .tick(tb_tick)
  );

  assign tb_cnt_next = timebase_counter_reg + {31'h0, tb_tick};
  assign test_cnt_next = test_cnt_reg + {31'h0, test_tick};

  // Fast and period modes end on the test target, slow on the timebase target, trigger on the end edge; the timebase target times out the rest.
  always_comb begin
    finish = 1'b0;
    timeout = 1'b0;
    if (phase_reg == freq_analyzer_pkg::RUN && !wr_abort) begin
      unique case (ctrl_reg.mode)
        freq_analyzer_pkg::TRIGGERED: begin
          finish = end_hit;
          timeout = ~end_hit & tb_tick & (tb_cnt_next >= tb_target_reg);
        end
        freq_analyzer_pkg::FREQ_TB_SLOW: begin
          finish = tb_tick & (tb_cnt_next >= tb_target_reg);
        end
        freq_analyzer_pkg::FREQ_TB_FAST,
        freq_analyzer_pkg::PERIOD: begin
          finish = test_tick & (test_cnt_next >= test_target_reg);
          timeout = ~finish & tb_tick & (tb_cnt_next >= tb_target_reg);
        end
      endcase
    end else if (phase_reg == freq_analyzer_pkg::ARMED && !wr_abort) begin
      timeout = tb_tick & (tb_cnt_next >= tb_target_reg);
    end
  end

  // More timebase counts per window means a slower clock under test.
  assign tb_span = tb_cnt_next - tb_start_cap_reg;
  always_comb begin
    if (ctrl_reg.mode == freq_analyzer_pkg::FREQ_TB_SLOW) begin
      above = test_cnt_next > test_high_reg;
      below = test_cnt_next < test_low_reg;
    end else begin
      above = tb_span < tb_low_reg;
      below = tb_span > tb_high_reg;
    end
  end

  always_comb begin
    phase_next = phase_reg;
    if (wr_abort) begin
      phase_next = freq_analyzer_pkg::IDLE;
    end else if (finish || timeout) begin
      phase_next = freq_analyzer_pkg::IDLE;
    end else if (begin_run) begin
      phase_next = freq_analyzer_pkg::RUN;
    end else if (arm) begin
      phase_next = freq_analyzer_pkg::ARMED;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= freq_analyzer_pkg::IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      start_prev_reg <= 1'b0;
      end_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_level;
      end_prev_reg <= end_level;
    end
  end

  // Counters restart on a timebase write or a launch and hold once stopped.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timebase_counter_reg <= 32'h00000000;
      test_cnt_reg <= 32'h00000000;
    end else if (wr_tb_cnt || launch) begin
      timebase_counter_reg <= 32'h00000000;
      test_cnt_reg <= 32'h00000000;
    end else if (phase_reg == freq_analyzer_pkg::RUN) begin
      timebase_counter_reg <= tb_cnt_next;
      test_cnt_reg <= test_cnt_next;
    end else if (phase_reg == freq_analyzer_pkg::ARMED) begin
      timebase_counter_reg <= tb_cnt_next;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tb_start_cap_reg <= 32'h00000000;
      tb_end_cap_reg <= 32'h00000000;
    end else begin
      if (launch) begin
        tb_start_cap_reg <= 32'h00000000;
      end else if (begin_run && !wr_abort) begin
        tb_start_cap_reg <= timebase_counter_reg;
      end
      if (finish) begin
        tb_end_cap_reg <= tb_cnt_next;
      end
    end
  end

  always_comb begin
    status_set = '0;
    status_set[`FA_ST_STARTED] = begin_run & ~wr_abort;
    status_set[`FA_ST_TB_STOPPED] = finish | timeout;
    status_set[`FA_ST_TEST_STOPPED] = finish | timeout;
    status_set[`FA_ST_TIMEOUT] = timeout;
    status_set[`FA_ST_IRQ] = finish | timeout;
    status_set[`FA_ST_ABOVE] = finish & above;
    status_set[`FA_ST_BELOW] = finish & below;
    status_clr = '0;
    if (wr_tb_cnt) begin
      status_clr = status_clr | `FA_ST_COUNTER_MASK;
    end
    if (write_at(`FA_STATUS_OFS)) begin
      status_clr = status_clr | (reg_wdata[`FA_ST_W-1:0] & `FA_ST_W1C_MASK);
    end
  end

  // A flag event in the same cycle as its clear survives.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= `FA_CTRL_RESET;
      irq_en_reg <= `FA_IRQ_EN_RESET;
      test_target_reg <= `FA_TARGET_RESET;
      tb_target_reg <= `FA_TARGET_RESET;
      test_low_reg <= `FA_LOW_RESET;
      test_high_reg <= `FA_HIGH_RESET;
      tb_low_reg <= `FA_LOW_RESET;
      tb_high_reg <= `FA_HIGH_RESET;
    end else if (reg_write) begin
      unique case (reg_addr)
        `FA_CTRL_OFS: ctrl_reg <= {reg_wdata[23:16], reg_wdata[13:0]};
        `FA_IRQ_EN_OFS: irq_en_reg <= reg_wdata[`FA_IEN_W-1:0];
        `FA_TEST_TARGET_OFS: test_target_reg <= reg_wdata;
        `FA_TB_TARGET_OFS: tb_target_reg <= reg_wdata;
        `FA_TEST_LOW_OFS: test_low_reg <= reg_wdata;
        `FA_TEST_HIGH_OFS: test_high_reg <= reg_wdata;
        `FA_TB_LOW_OFS: tb_low_reg <= reg_wdata;
        `FA_TB_HIGH_OFS: tb_high_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      unique case (reg_addr)
        `FA_CTRL_OFS: reg_rdata <= {8'h00, ctrl_reg.prediv, 2'h0, ctrl_reg[13:0]};
        `FA_IRQ_EN_OFS: reg_rdata <= {29'h00000000, irq_en_reg};
        `FA_STATUS_OFS: reg_rdata <= {25'h0000000, status_reg};
        `FA_TEST_CNT_OFS: reg_rdata <= test_cnt_reg;
        `FA_TB_CNT_OFS: reg_rdata <= timebase_counter_reg;
        `FA_TEST_TARGET_OFS: reg_rdata <= test_target_reg;
        `FA_TB_TARGET_OFS: reg_rdata <= tb_target_reg;
        `FA_TB_START_CAP_OFS: reg_rdata <= tb_start_cap_reg;
        `FA_TB_END_CAP_OFS: reg_rdata <= tb_end_cap_reg;
        `FA_TEST_LOW_OFS: reg_rdata <= test_low_reg;
        `FA_TEST_HIGH_OFS: reg_rdata <= test_high_reg;
        `FA_TB_LOW_OFS: reg_rdata <= tb_low_reg;
        `FA_TB_HIGH_OFS: reg_rdata <= tb_high_reg;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // The pin copy lags the sampled clock by one cycle; it is a monitor, not a timing source.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      test_clock_pin <= 1'b0;
    end else begin
      test_clock_pin <= ctrl_reg.test_clock_pin_connect & test_level;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_measure <= 1'b0;
      irq_above_max <= 1'b0;
      irq_below_min <= 1'b0;
    end else begin
      irq_measure <= irq_en_reg[`FA_IEN_MEASURE] & status_reg[`FA_ST_IRQ];
      irq_above_max <= irq_en_reg[`FA_IEN_ABOVE] & status_reg[`FA_ST_ABOVE];
      irq_below_min <= irq_en_reg[`FA_IEN_BELOW] & status_reg[`FA_ST_BELOW];
    end
  end

endmodule : freq_analyzer

// ===== freq_analyzer_map.svh
`ifndef FREQ_ANALYZER_MAP_SVH
`define FREQ_ANALYZER_MAP_SVH

`define FA_ADDR_W 8
`define FA_DATA_W 32

`define FA_CTRL_OFS 8'h00
`define FA_IRQ_EN_OFS 8'h04
`define FA_STATUS_OFS 8'h08
`define FA_TEST_CNT_OFS 8'h0C
`define FA_TB_CNT_OFS 8'h10
`define FA_TEST_TARGET_OFS 8'h14
`define FA_TB_TARGET_OFS 8'h18
`define FA_TB_START_CAP_OFS 8'h1C
`define FA_TB_END_CAP_OFS 8'h20
`define FA_TEST_LOW_OFS 8'h24
`define FA_TEST_HIGH_OFS 8'h28
`define FA_TB_LOW_OFS 8'h2C
`define FA_TB_HIGH_OFS 8'h30
`define FA_ABORT_OFS 8'h34

`define FA_ST_TB_STOPPED 0
`define FA_ST_TEST_STOPPED 1
`define FA_ST_STARTED 2
`define FA_ST_TIMEOUT 3
`define FA_ST_IRQ 4
`define FA_ST_ABOVE 5
`define FA_ST_BELOW 6
`define FA_ST_W 7
`define FA_ST_W1C_MASK 7'h70
`define FA_ST_COUNTER_MASK 7'h0F

`define FA_IEN_MEASURE 0
`define FA_IEN_ABOVE 1
`define FA_IEN_BELOW 2
`define FA_IEN_W 3

`define FA_CTRL_W 22
// Reset value in the packed control layout: predivider one, everything else clear.
`define FA_CTRL_RESET 22'h004000
`define FA_IRQ_EN_RESET 3'h0
`define FA_TARGET_RESET 32'hFFFFFFFF
`define FA_LOW_RESET 32'h00000000
`define FA_HIGH_RESET 32'hFFFFFFFF

`endif

// ===== freq_analyzer_pkg.sv
package freq_analyzer_pkg;

  typedef enum logic [1:0] {
    FREQ_TB_FAST,
    FREQ_TB_SLOW,
    PERIOD,
    TRIGGERED
  } mode_e;

  typedef enum logic [1:0] {
    IDLE,
    ARMED,
    RUN
  } phase_e;

  typedef struct packed {
    logic [7:0] prediv;
    logic test_clock_pin_connect;
    logic trigger_mode_enable;
    logic end_edge_polarity;
    logic end_trigger_select;
    logic start_edge_polarity;
    logic start_trigger_select;
    logic [1:0] timebase_select;
    logic [3:0] test_clock_select;
    mode_e mode;
  } ctrl_s;

endpackage : freq_analyzer_pkg

// ===== freq_analyzer_sva.sv
`include "freq_analyzer_map.svh"

module freq_analyzer_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] test_clocks,
  input wire logic [`FA_ADDR_W-1:0] reg_addr,
  input wire logic [`FA_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [`FA_DATA_W-1:0] reg_rdata,
  input wire logic test_clock_pin,
  input wire logic irq_measure,
  input wire logic irq_above_max,
  input wire logic irq_below_min
);
  logic [2:0] ien_reg;
  logic [31:0] ctrl_reg;
  logic pin_next;
  logic rd_unmapped;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Shadows of the control and interrupt enable registers, so that readback and gating can be judged.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ien_reg <= 3'h0;
    end else if (reg_write && reg_addr == `FA_IRQ_EN_OFS) begin
      ien_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= 32'h00010000;
    end else if (reg_write && reg_addr == `FA_CTRL_OFS) begin
      ctrl_reg <= reg_wdata & 32'h00FF3FFF;
    end
  end

  assign pin_next = ctrl_reg[13] & test_clocks[ctrl_reg[5:2]];
  assign rd_unmapped = reg_addr > `FA_ABORT_OFS || reg_addr[1:0] != 2'h0;

  sequence s_ien_clear;
    reg_write && reg_addr == `FA_IRQ_EN_OFS && reg_wdata[2:0] == 3'h0;
  endsequence

  property p_irq_off;
    s_ien_clear |-> ##2 !(irq_measure || irq_above_max || irq_below_min);
  endproperty

  property p_unmapped_zero;
    $past(reg_read) && $past(rd_unmapped) |-> reg_rdata == 32'h0;
  endproperty

  property p_ien_readback;
    $past(reg_read) && $past(reg_addr) == `FA_IRQ_EN_OFS
      |-> reg_rdata == {29'h0, $past(ien_reg)};
  endproperty

  property p_ctrl_readback;
    $past(reg_read) && $past(reg_addr) == `FA_CTRL_OFS |-> reg_rdata == $past(ctrl_reg);
  endproperty

  a_rdata_idle: assert property (reg_rdata != 32'h0 |-> $past(reg_read))
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");
  a_ien_readback: assert property (p_ien_readback)
    else $error("enable readback wrong");
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control readback wrong");
  a_pin_follow: assert property (test_clock_pin == $past(pin_next))
    else $error("test clock pin wrong");
  a_measure_gate: assert property (irq_measure |-> $past(ien_reg[0]))
    else $error("measure request while disabled");
  a_above_gate: assert property (irq_above_max |-> $past(ien_reg[1]))
    else $error("above request while disabled");
  a_below_gate: assert property (irq_below_min |-> $past(ien_reg[2]))
    else $error("below request while disabled");
  a_irq_all_off: assert property (p_irq_off)
    else $error("requests stay after disable");
endmodule : freq_analyzer_sva

bind freq_analyzer freq_analyzer_sva sva_inst (.core_clk(core_clk), .reset(reset),
  .test_clocks(test_clocks), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .test_clock_pin(test_clock_pin), .irq_measure(irq_measure),
  .irq_above_max(irq_above_max), .irq_below_min(irq_below_min));

// ===== freq_analyzer_tb.sv
`include "freq_analyzer_map.svh"

module freq_analyzer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, reg_write, reg_read, test_clock_pin;
  logic irq_measure, irq_above_max, irq_below_min;
  logic [15:0] test_clocks = 16'h0000;
  logic [2:0] timebase_clocks = 3'h0;
  logic [1:0] start_trigger_in, end_trigger_in;
  logic [7:0] reg_addr;
  logic [7:0] ph = 8'h00;
  logic [31:0] reg_wdata, reg_rdata, rd;
  int n_mismatch, tests_run;
  int cyc = 0;
  logic [39:0] rv [0:13] = '{{`FA_CTRL_OFS, 32'h00010000}, {`FA_IRQ_EN_OFS, 32'h0},
    {`FA_STATUS_OFS, 32'h0}, {`FA_TEST_CNT_OFS, 32'h0}, {`FA_TB_CNT_OFS, 32'h0},
    {`FA_TEST_TARGET_OFS, 32'hFFFFFFFF}, {`FA_TB_TARGET_OFS, 32'hFFFFFFFF},
    {`FA_TB_START_CAP_OFS, 32'h0}, {`FA_TB_END_CAP_OFS, 32'h0}, {`FA_TEST_LOW_OFS, 32'h0},
    {`FA_TEST_HIGH_OFS, 32'hFFFFFFFF}, {`FA_TB_LOW_OFS, 32'h0},
    {`FA_TB_HIGH_OFS, 32'hFFFFFFFF}, {8'h38, 32'h0}};

  freq_analyzer DUT (.core_clk(core_clk), .reset(reset), .test_clocks(test_clocks),
    .timebase_clocks(timebase_clocks), .start_trigger_in(start_trigger_in),
    .end_trigger_in(end_trigger_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .test_clock_pin(test_clock_pin), .irq_measure(irq_measure),
    .irq_above_max(irq_above_max), .irq_below_min(irq_below_min));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Measured clocks are kept well below half the core rate so every edge is sampled.
  always @(posedge core_clk) begin
    ph <= ph + 8'h1;
    test_clocks <= ph[3] ? 16'hAAAA : 16'h5555;
    timebase_clocks <= {ph[2], ph[1], ph[1]};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd_word(input logic [7:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
    @(posedge core_clk);
  endtask : rd_word

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd_word(a);
    chk(rd, e);
  endtask : rd_chk

  task automatic wait_irq;
    for (int i = 0; i < 3000 && irq_measure !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    chk({31'h0, irq_measure}, 32'h1);
  endtask : wait_irq

  task automatic run(input logic [31:0] ctrl, input logic [31:0] st);
    wr(`FA_CTRL_OFS, ctrl);
    wr(`FA_TB_CNT_OFS, 32'h0);
    wr(`FA_TEST_CNT_OFS, 32'h0);
    wait_irq();
    chk({30'h0, irq_below_min, irq_above_max}, {30'h0, st[6:5]});
    rd_chk(`FA_STATUS_OFS, st);
    wr(`FA_STATUS_OFS, 32'h70);
  endtask : run

  initial begin
    logic acc;
    logic hi;
    logic lo;
    reset = 1'b1;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {n_mismatch, tests_run} = '0;
    start_trigger_in = 2'b11;
    end_trigger_in = 2'b00;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (rv[i]) rd_chk(rv[i][39:32], rv[i][31:0]);
    wr(`FA_TB_START_CAP_OFS, 32'h5);
    wr(8'h38, 32'h1);
    rd_chk(`FA_TB_START_CAP_OFS, 32'h0);
    wr(`FA_CTRL_OFS, 32'hFFFFFFFF);
    rd_chk(`FA_CTRL_OFS, 32'h00FF3FFF);
    // Every selected clock must reach the pin and toggle there within twenty cycles.
    for (int s = 0; s < 16; s++) begin
      wr(`FA_CTRL_OFS, 32'h00012000 | (s << 2));
      hi = 1'b0;
      lo = 1'b0;
      repeat (20) begin
        @(posedge core_clk);
        hi = hi | test_clock_pin;
        lo = lo | ~test_clock_pin;
      end
      chk({30'h0, hi, lo}, 32'h3);
    end
    wr(`FA_CTRL_OFS, 32'h00010000);
    acc = 1'b0;
    repeat (20) begin
      @(posedge core_clk);
      acc = acc | test_clock_pin;
    end
    chk({31'h0, acc}, 32'h0);
    wr(`FA_IRQ_EN_OFS, 32'h7);
    wr(`FA_TEST_TARGET_OFS, 32'h4);
    wr(`FA_TB_LOW_OFS, 32'd10);
    wr(`FA_TB_HIGH_OFS, 32'd20);
    // The first test edge may land late, so spans allow one test period of slack.
    for (int m = 0; m < 3; m += 2) begin
      for (int t = 0; t < 3; t++) begin
        run(32'h00010000 | (t << 6) | m, t == 2 ? 32'h37 : 32'h17);
        rd_word(`FA_TB_END_CAP_OFS);
        chk(t == 2 ? (rd >= 5 && rd <= 9) : (rd >= 11 && rd <= 17), 32'h1);
      end
    end
    wr(`FA_TB_TARGET_OFS, 32'd32);
    wr(`FA_TEST_LOW_OFS, 32'd5);
    wr(`FA_TEST_HIGH_OFS, 32'd6);
    run(32'h00010001, 32'h37);
    run(32'h00040001, 32'h57);
    wr(`FA_TEST_TARGET_OFS, 32'd100);
    run(32'h00010002, 32'h1F);
    wr(`FA_TB_TARGET_OFS, 32'hFFFFFFFF);
    wr(`FA_TB_CNT_OFS, 32'h0);
    wr(`FA_TEST_CNT_OFS, 32'h0);
    wr(`FA_ABORT_OFS, 32'h1);
    repeat (200) @(posedge core_clk);
    rd_word(`FA_STATUS_OFS);
    chk(rd & 32'h7B, 32'h0);
    wr(`FA_TEST_TARGET_OFS, 32'h4);
    run(32'h00010002, 32'h17);
    wr(`FA_CTRL_OFS, 32'h00011303);
    wr(`FA_TB_CNT_OFS, 32'h0);
    start_trigger_in <= 2'b10;
    repeat (8) @(posedge core_clk);
    rd_word(`FA_STATUS_OFS);
    chk(rd & 32'h4, 32'h0);
    start_trigger_in <= 2'b00;
    repeat (8) @(posedge core_clk);
    rd_word(`FA_STATUS_OFS);
    chk(rd & 32'h7, 32'h4);
    end_trigger_in <= 2'b10;
    repeat (8) @(posedge core_clk);
    rd_word(`FA_STATUS_OFS);
    chk(rd & 32'h3, 32'h0);
    end_trigger_in <= 2'b11;
    wait_irq();
    rd_word(`FA_STATUS_OFS);
    chk(rd & 32'h17, 32'h17);
    wr(`FA_TB_CNT_OFS, 32'h0);
    rd_word(`FA_STATUS_OFS);
    chk(rd & 32'h1F, 32'h10);
    wr(`FA_IRQ_EN_OFS, 32'h0);
    wr(`FA_STATUS_OFS, 32'h70);
    rd_chk(`FA_STATUS_OFS, 32'h0);
    report_and_stop();
  end
endmodule : freq_analyzer_tb
